//--- bench/hci_uart_transport_chk.sv
// Port checker for the host transport serial port
`timescale 1ns/1ps

module hci_uart_transport_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Wishbone slave and configuration record load
    input wire logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    input wire logic ack_o,
    input wire logic cfgLoad,
    // Serial link
    input wire logic txd,
    input wire logic rtsN
);
    logic [7:0] hiCnt;
    logic [7:0] loCnt;

    // Saturating run lengths of txd; a reset counts as a long idle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hiCnt <= 8'hFF;
            loCnt <= 8'h00;
        end else begin
            hiCnt <= txd ? hiCnt + {7'h00, hiCnt != 8'hFF} : 8'h00;
            loCnt <= !txd ? loCnt + {7'h00, loCnt != 8'hFF} : 8'h00;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Bus answer timing and read data shape
    property p_ack_next;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once;
        ack_o |=> !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_cause;
        ack_o |-> $past(cyc_i && stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_zero;
        !ack_o |-> dat_o == 32'h0000_0000;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
    property p_upper_zero;
        ack_o |-> dat_o[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

    // Line levels around reset release
    property p_rst_lines;
        $rose(reset_n) |-> txd && rtsN ##1 !rtsN;
    endproperty
    a_rst_lines: assert property (p_rst_lines) else $error("lines wrong after reset");

    // No bit shorter than 40 mclk, below the fastest bit period of 41 mclk
    property p_low_run;
        $rose(txd) |-> loCnt >= 8'h28;
    endproperty
    a_low_run: assert property (p_low_run) else $error("low bit too short");
    property p_high_run;
        $fell(txd) |-> hiCnt >= 8'h28;
    endproperty
    a_high_run: assert property (p_high_run) else $error("high bit too short");

    // Main scenarios
    c_cfg: cover property (cfgLoad);
    c_read: cover property (ack_o && !we_i);
    c_start: cover property ($fell(txd));
endmodule : hci_uart_transport_chk

bind hci_uart_transport hci_uart_transport_chk chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .dat_o(dat_o),
    .we_i(we_i),
    .stb_i(stb_i),
    .cyc_i(cyc_i),
    .ack_o(ack_o),
    .cfgLoad(cfgLoad),
    .txd(txd),
    .rtsN(rtsN)
);

//--- bench/host_uart_model.sv
// Host side serial partner: receives device characters and sends its own
`timescale 1ns/1ps

module host_uart_model (
    // Clock and controls
    input wire logic mclk,
    input int bitNs,
    input wire logic hold,
    // Serial link without request-to-send
    input wire logic txd,
    output logic rxd,
    output logic ctsN,
    // Received characters
    output logic gotValid,
    output logic [7:0] gotByte
);
    logic [7:0] shift;

    // Clear-to-send follows the hold request; rxd idles high
    assign ctsN = hold;
    initial begin
        rxd = 1'b1;
        gotValid = 1'b0;
        gotByte = 8'h00;
    end

    // Mid-bit sampling, LSB first; a low stop bit drops the character
    always begin
        @(negedge txd);
        #(bitNs / 2);
        if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                #(bitNs);
                shift[i] = txd;
            end
            #(bitNs);
            @(posedge mclk);
            gotByte <= shift;
            gotValid <= txd;
            @(posedge mclk);
            gotValid <= 1'b0;
        end
    end

    // One 8N1 character toward the device
    task automatic send(input logic [7:0] b);
        @(posedge mclk);
        rxd <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            #(bitNs);
            rxd <= b[i];
        end
        #(bitNs);
        rxd <= 1'b1;
        #(bitNs);
    endtask : send
endmodule : host_uart_model

//--- bench/tb_hci_uart_transport.sv
// Self-checking bench for the host transport serial port
`timescale 1ns/1ps
`include "hci_uart_consts.svh"

module tb_hci_uart_transport;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic mclk = 1'b0, reset_n = 1'b0, we_i = 1'b0, stb_i = 1'b0, cyc_i = 1'b0;
    logic cfgLoad = 1'b0, hold = 1'b0, sawLow;
    logic [7:0] adr_i = 8'h00, cfgDivisor = 8'h00, cfgAdjust = 8'h00, gotByte;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic [3:0] sel_i = 4'h1;
    logic ack_o, rxd, txd, ctsN, rtsN, gotValid;
    logic [15:0] lfsr = 16'h7AB3;
    int bitNs = 8667, mismatches = 0, num_checks = 0;
    logic [31:0] rdExp[$], rdMask[$];
    logic [7:0] txExp[$];
    logic [7:0] modeDiv[4] = '{8'h01, 8'h01, 8'h01, 8'h03};
    logic [7:0] modeAdj[4] = '{8'h88, 8'h00, 8'hFF, 8'h44};
    logic [3:0] modeCtl = 4'b0110;
    int modeNs[4] = '{1333, 333, 667, 2333};

    // 125 MHz clock
    initial begin
        forever #4 mclk = ~mclk;
    end

    hci_uart_transport uut (.mclk(mclk), .reset_n(reset_n), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i),
        .ack_o(ack_o), .cfgLoad(cfgLoad), .cfgDivisor(cfgDivisor), .cfgAdjust(cfgAdjust),
        .rxd(rxd), .txd(txd), .ctsN(ctsN), .rtsN(rtsN));
    host_uart_model model (.mclk(mclk), .bitNs(bitNs), .hold(hold), .txd(txd), .rxd(rxd),
        .ctsN(ctsN), .gotValid(gotValid), .gotByte(gotByte));

    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : step

    task automatic chkWord(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chkWord

    task automatic chkByte(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chkByte

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge mclk);
        while (ack_o !== 1'b1) @(posedge mclk);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rdExp.push_back(e);
        rdMask.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h00_0000, d});
    endtask : wr

    task automatic put(input logic [7:0] b);
        txExp.push_back(b);
        wr(`OFF_DATA, b);
    endtask : put

    task automatic waitTx();
        for (int n = 0; n < 20000 && txExp.size() != 0; n++) @(posedge mclk);
        chkWord("pending tx notes", 32'h0000_0000, 32'(txExp.size()));
    endtask : waitTx

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Oldest note against each read answer and each host character
    always @(posedge mclk) begin
        if (ack_o === 1'b1 && we_i === 1'b0)
            chkWord("read data", rdExp.pop_front(), dat_o & rdMask.pop_front());
        if (gotValid === 1'b1)
            chkByte("host byte", txExp.pop_front(), gotByte);
    end

    // Cut a hang short, well past the expected 50000 cycles
    initial begin
        #(8 * 90000);
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`OFF_STATUS, 32'h0000_0024, 32'h0000_003F);
        rd(`OFF_DIVISOR, 32'h0000_000D, ALL);
        rd(`OFF_ADJUST, 32'h0000_0000, ALL);
        rd(`OFF_CONTROL, 32'h0000_0000, ALL);
        rd(`OFF_DATA, 32'h0000_0000, ALL);
        rd(8'h14, 32'h0000_0000, ALL);
        put(8'hA5);
        waitTx();
        @(posedge mclk);
        cfgLoad <= 1'b1;
        cfgDivisor <= 8'h01;
        cfgAdjust <= 8'h21;
        @(posedge mclk);
        cfgLoad <= 1'b0;
        rd(`OFF_DIVISOR, 32'h0000_0001, ALL);
        rd(`OFF_ADJUST, 32'h0000_0021, ALL);
        rd(`OFF_STATUS, 32'h0000_0000, 32'h0000_0004);
        for (int k = 0; k < 4; k++) begin
            wr(`OFF_DIVISOR, modeDiv[k]);
            wr(`OFF_ADJUST, modeAdj[k]);
            wr(`OFF_CONTROL, {7'h00, modeCtl[k]});
            bitNs = modeNs[k];
            repeat (2) begin
                lfsr = step(lfsr);
                put(lfsr[7:0]);
            end
            waitTx();
            lfsr = step(lfsr);
            model.send(lfsr[7:0]);
            rd(`OFF_STATUS, 32'h0000_0001, 32'h0000_0009);
            rd(`OFF_DATA, {24'h00_0000, lfsr[7:0]}, ALL);
        end
        hold <= 1'b1;
        repeat (4) @(posedge mclk);
        put(8'h5A);
        rd(`OFF_STATUS, 32'h0000_0000, 32'h0000_0020);
        sawLow = 1'b0;
        repeat (2000) @(posedge mclk) if (txd !== 1'b1) sawLow = 1'b1;
        chkByte("txd held", 8'h00, {7'h00, sawLow});
        hold <= 1'b0;
        rd(`OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
        waitTx();
        hold <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 1039; k++) wr(`OFF_DATA, 8'h3C);
        rd(`OFF_STATUS, 32'h0000_0000, 32'h0000_0002);
        wr(`OFF_DATA, 8'h3C);
        rd(`OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        hold <= 1'b0;
        rd(`OFF_STATUS, 32'h0000_0024, 32'h0000_003F);
        repeat (12000) @(posedge mclk);
        stop_test();
    end
endmodule : tb_hci_uart_transport

//--- common/hci_uart_consts.svh
// Constants for the host transport serial port
`ifndef HCI_UART_CONSTS_SVH
`define HCI_UART_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define OFF_DATA 8'h00
`define OFF_STATUS 8'h04
`define OFF_DIVISOR 8'h08
`define OFF_ADJUST 8'h0C
`define OFF_CONTROL 8'h10

// Status register bit positions
`define ST_RX_AVAIL 0
`define ST_TX_FULL 1
`define ST_BOOT 2
`define ST_OVERRUN 3
`define ST_TX_BUSY 4
`define ST_CTS 5

// Control register bit positions
`define CTL_CLK48 0

// Reset values: 24 MHz engine, 16 x 13 engine cycles per bit gives 115200 baud
`define DIV_RESET 8'h0D
`define ADJ_RESET 8'h00
`define CTL_RESET 8'h00

// Adjustment nibbles saturate at eight stuffed cycles
`define ADJ_MAX 4'h8

// Queue depth, and the fill level that drops request-to-send
`define FIFO_DEPTH 11'h0410
`define FIFO_LAST 11'h040F
`define RX_RTS_LEVEL 11'h0400

// Engine clock made from mclk (125 MHz) by a phase accumulator, in MHz
`define MCLK_MHZ 8'h7D
`define ENG_MHZ_LOW 8'h18
`define ENG_MHZ_HIGH 8'h30

// Index of the last of the eight data bits in a character
`define DATA_BITS 3'h7

`endif

//--- common/hci_uart_pkg.sv
// Types shared by the host transport serial port
package hci_uart_pkg;

    // Transmit character sequencer
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } txState_t;

    // Receive character sequencer
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rxState_t;

endpackage : hci_uart_pkg

//--- hw/hci_uart_transport.sv
// Host transport serial port with queues, baud generator and Wishbone slave
// How it works
// R1: Link has receive, transmit, request-to-send and clear-to-send lines.
// R2: Bit rates programmable from 38400 bps up to 4 Mbps; the code tops out at 3 Mbps (48 MHz engine, divisor 1).
// R3: Host expects no more than 750 kbps during boot.
// R4: Host changes rate at runtime; software rewrites the rate registers.
// R5: After reset the rate comes from a downloaded configuration record.
// R6: Separate 1040-byte receive and transmit queues.
// R7: Link traffic follows the H4 packet transport on both sides.
// R8: Default rate is 115.2 kbaud.
// R9: Engine clock defaults to 24 MHz, selectable up to 48 MHz.
// R10: Bit period is the engine clock divided by sixteen times the divisor.
// R11: Zero to eight extra engine cycles go into each first half-bit.
// R12: Zero to eight extra engine cycles go at each bit end.
// R13: Combined rate error of both sides stays within two percent.
// R14: Rate setting is part of the start-up configuration store.
// R15: Engine clock derives from the module's 24 MHz reference; the code derives it from the 125 MHz mclk.
// R16: Send only while clear-to-send; drop request-to-send near queue full.
// R17: Frames are start bit, eight data bits LSB first, stop bit.
`timescale 1ns/1ps
`include "hci_uart_consts.svh"

module hci_uart_transport
    import hci_uart_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    output logic ack_o,
    // Configuration record from the start-up store
    input wire logic cfgLoad,
    input wire logic [7:0] cfgDivisor,
    input wire logic [7:0] cfgAdjust,
    // Serial link
    input wire logic rxd,
    output logic txd,
    input wire logic ctsN,
    output logic rtsN
);

    // Register file
    logic [7:0] divisor_reg;
    logic [7:0] adjust_reg;
    logic [7:0] control_reg;
    logic bootPhase_reg;
    logic overrun_reg;
    logic ack_next;

    // Queues
    logic [7:0] rxMem [0:1039];
    logic [7:0] txMem [0:1039];
    logic [10:0] rxWr_reg;
    logic [10:0] rxRd_reg;
    logic [10:0] rxCount_reg;
    logic [10:0] txWr_reg;
    logic [10:0] txRd_reg;
    logic [10:0] txCount_reg;

    // Engine clock accumulator
    logic [7:0] engAcc_reg;
    logic [7:0] engAcc_next;
    logic engTick;

    // Transmitter and receiver
    txState_t txState_reg;
    txState_t txState_next;
    rxState_t rxState_reg;
    rxState_t rxState_next;
    logic [7:0] txShift_reg;
    logic [2:0] txBit_reg;
    logic [7:0] rxShift_reg;
    logic [2:0] rxBit_reg;
    logic txMid;
    logic txEnd;
    logic rxMid;
    logic rxEnd;

    // Bus decode
    wire access = cyc_i && stb_i && !ack_o;
    wire [7:0] wordAdr = {adr_i[7:2], 2'b00};
    wire hitData = wordAdr == `OFF_DATA;
    wire hitStatus = wordAdr == `OFF_STATUS;
    wire hitDivisor = wordAdr == `OFF_DIVISOR;
    wire hitAdjust = wordAdr == `OFF_ADJUST;
    wire hitControl = wordAdr == `OFF_CONTROL;
    wire wrLow = access && we_i && sel_i[0];
    wire rdAccess = access && !we_i;

    // Queue flags and strobes
    wire rxEmpty = rxCount_reg == 11'h000;
    wire rxFull = rxCount_reg == `FIFO_DEPTH;
    wire txEmpty = txCount_reg == 11'h000;
    wire txFull = txCount_reg == `FIFO_DEPTH;
    wire txPush = wrLow && hitData && !txFull; // see R6
    wire rxPop = rdAccess && hitData && !rxEmpty;
    wire txLoad = (txState_reg == TX_IDLE) && !txEmpty && !ctsN; // see R16
    wire txPop = txLoad;
    wire rxDone = (rxState_reg == RX_STOP) && rxMid && rxd;
    wire rxPush = rxDone && !rxFull; // see R6
    wire rxLost = rxDone && rxFull;
    wire ovrClear = wrLow && hitStatus && dat_i[`ST_OVERRUN];

    // Adjustment nibbles, each saturated at eight cycles
    wire [3:0] adjFirst = (adjust_reg[7:4] > `ADJ_MAX) ? `ADJ_MAX : adjust_reg[7:4]; // see R11
    wire [3:0] adjEnd = (adjust_reg[3:0] > `ADJ_MAX) ? `ADJ_MAX : adjust_reg[3:0]; // see R12

    // Engine tick step: 24 MHz by default, 48 MHz when selected
    wire [7:0] engStep = control_reg[`CTL_CLK48] ? `ENG_MHZ_HIGH : `ENG_MHZ_LOW; // see R9
    wire [8:0] engSum = {1'b0, engAcc_reg} + {1'b0, engStep};

    // Status word shows queue, boot and link state
    wire [7:0] statusWord = {2'b00, !ctsN, txState_reg != TX_IDLE, overrun_reg,
        bootPhase_reg, txFull, !rxEmpty};

    // Read multiplexer; unmapped offsets read as zero
    wire [7:0] rdByte = hitData ? (rxEmpty ? 8'h00 : rxMem[rxRd_reg[10:0]]) :
        hitStatus ? statusWord :
        hitDivisor ? divisor_reg :
        hitAdjust ? adjust_reg :
        hitControl ? control_reg : 8'h00;

    // Wishbone answers one cycle after the strobe, for any address
    assign ack_next = access;

    // Bus acknowledge and read data
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= ack_next;
            dat_o <= rdAccess ? {24'h00_0000, rdByte} : 32'h0000_0000;
        end
    end

    // Rate registers: start-up record or runtime rewrite by software
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            divisor_reg <= `DIV_RESET; // see R8
            adjust_reg <= `ADJ_RESET;
            control_reg <= `CTL_RESET; // see R9
        end else if (cfgLoad) begin
            divisor_reg <= cfgDivisor; // see R5 see R14
            adjust_reg <= cfgAdjust;
        end else begin
            if (wrLow && hitDivisor) begin
                divisor_reg <= dat_i[7:0]; // see R4 see R2
            end
            if (wrLow && hitAdjust) begin
                adjust_reg <= dat_i[7:0]; // see R4
            end
            if (wrLow && hitControl) begin
                control_reg <= {7'h00, dat_i[`CTL_CLK48]};
            end
        end
    end

    // Boot flag until the record arrives; overrun is sticky, set beats clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bootPhase_reg <= 1'b1; // see R3
            overrun_reg <= 1'b0;
        end else begin
            if (cfgLoad) begin
                bootPhase_reg <= 1'b0;
            end
            if (rxLost) begin
                overrun_reg <= 1'b1;
            end else if (ovrClear) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    // Engine clock from mclk by phase accumulation
    always_comb begin
        engTick = engSum >= {1'b0, `MCLK_MHZ};
        engAcc_next = engTick ? 8'(engSum - {1'b0, `MCLK_MHZ}) : engSum[7:0];
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            engAcc_reg <= 8'h00;
        end else begin
            engAcc_reg <= engAcc_next; // see R15 see R13
        end
    end

    // Queue storage writes
    always_ff @(posedge mclk) begin
        if (txPush) begin
            txMem[txWr_reg] <= dat_i[7:0];
        end
        if (rxPush) begin
            rxMem[rxWr_reg] <= rxShift_reg;
        end
    end

    // Transmit queue pointers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            txWr_reg <= 11'h000;
            txRd_reg <= 11'h000;
            txCount_reg <= 11'h000;
        end else begin
            if (txPush) begin
                txWr_reg <= (txWr_reg == `FIFO_LAST) ? 11'h000 : txWr_reg + 11'h001;
            end
            if (txPop) begin
                txRd_reg <= (txRd_reg == `FIFO_LAST) ? 11'h000 : txRd_reg + 11'h001;
            end
            txCount_reg <= txCount_reg + {10'h000, txPush} - {10'h000, txPop};
        end
    end

    // Receive queue pointers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rxWr_reg <= 11'h000;
            rxRd_reg <= 11'h000;
            rxCount_reg <= 11'h000;
        end else begin
            if (rxPush) begin
                rxWr_reg <= (rxWr_reg == `FIFO_LAST) ? 11'h000 : rxWr_reg + 11'h001;
            end
            if (rxPop) begin
                rxRd_reg <= (rxRd_reg == `FIFO_LAST) ? 11'h000 : rxRd_reg + 11'h001;
            end
            rxCount_reg <= rxCount_reg + {10'h000, rxPush} - {10'h000, rxPop};
        end
    end

    // Flow control: hold off the host when the receive queue nears full
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rtsN <= 1'b1;
        end else begin
            rtsN <= rxCount_reg >= `RX_RTS_LEVEL; // see R16 see R1
        end
    end

    // Bit timers for each direction
    uart_bit_timer txTimer (
        .mclk(mclk),
        .reset_n(reset_n),
        .engTick(engTick),
        .restart(txLoad),
        .divisor(divisor_reg),
        .adjFirst(adjFirst),
        .adjEnd(adjEnd),
        .midTick(txMid),
        .endTick(txEnd)
    );

    uart_bit_timer rxTimer (
        .mclk(mclk),
        .reset_n(reset_n),
        .engTick(engTick),
        .restart(rxState_reg == RX_IDLE && !rxd),
        .divisor(divisor_reg),
        .adjFirst(adjFirst),
        .adjEnd(adjEnd),
        .midTick(rxMid),
        .endTick(rxEnd)
    );

    // Transmit sequencer: start, eight bits LSB first, stop
    always_comb begin
        txState_next = txState_reg;
        unique case (txState_reg)
            TX_IDLE: begin
                if (txLoad) begin
                    txState_next = TX_START;
                end
            end
            TX_START: begin
                if (txEnd) begin
                    txState_next = TX_DATA;
                end
            end
            TX_DATA: begin
                if (txEnd && txBit_reg == `DATA_BITS) begin
                    txState_next = TX_STOP;
                end
            end
            TX_STOP: begin
                if (txEnd) begin
                    txState_next = TX_IDLE;
                end
            end
        endcase
    end

    // Transmit shifter and line driver
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            txState_reg <= TX_IDLE;
            txShift_reg <= 8'h00;
            txBit_reg <= 3'h0;
            txd <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            if (txLoad) begin
                txShift_reg <= txMem[txRd_reg];
                txBit_reg <= 3'h0;
                txd <= 1'b0; // see R17 see R7
            end else if (txEnd && txState_reg != TX_IDLE) begin
                if (txState_next == TX_DATA) begin
                    txd <= txShift_reg[0]; // see R17
                    txShift_reg <= {1'b0, txShift_reg[7:1]};
                    txBit_reg <= (txState_reg == TX_DATA) ? txBit_reg + 3'h1 : 3'h0;
                end else begin
                    txd <= 1'b1;
                end
            end
        end
    end

    // Receive sequencer: verify start at mid-bit, sample data, check stop
    always_comb begin
        rxState_next = rxState_reg;
        unique case (rxState_reg)
            RX_IDLE: begin
                if (!rxd) begin
                    rxState_next = RX_START;
                end
            end
            RX_START: begin
                if (rxMid) begin
                    rxState_next = rxd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxMid && rxBit_reg == `DATA_BITS) begin
                    rxState_next = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rxMid) begin
                    rxState_next = RX_IDLE;
                end
            end
        endcase
    end

    // Receive shifter
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rxState_reg <= RX_IDLE;
            rxShift_reg <= 8'h00;
            rxBit_reg <= 3'h0;
        end else begin
            rxState_reg <= rxState_next;
            if (rxState_reg == RX_START) begin
                rxBit_reg <= 3'h0;
            end else if (rxState_reg == RX_DATA && rxMid) begin
                rxShift_reg <= {rxd, rxShift_reg[7:1]}; // see R17
                rxBit_reg <= rxBit_reg + 3'h1;
            end
        end
    end

endmodule : hci_uart_transport

//--- hw/uart_bit_timer.sv
// Bit period timer counting serial engine cycles with stuffed cycles
`timescale 1ns/1ps
`include "hci_uart_consts.svh"

module uart_bit_timer
    import hci_uart_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Timing controls
    input wire logic engTick,
    input wire logic restart,
    input wire logic [7:0] divisor,
    input wire logic [3:0] adjFirst,
    input wire logic [3:0] adjEnd,
    // Bit events
    output logic midTick,
    output logic endTick
);

    logic [12:0] cnt_reg;
    logic [12:0] cnt_next;
    logic midTick_next;
    logic endTick_next;
    wire [12:0] halfLen;
    wire [12:0] fullLen;
    wire atHalf;
    wire atEnd;

    // Nominal period is sixteen times the divisor; extra cycles go early and late
    assign halfLen = {2'b00, divisor, 3'b000} + {9'h000, adjFirst}; // see R11
    assign fullLen = {1'b0, divisor, 4'b0000} + {9'h000, adjFirst}
        + {9'h000, adjEnd}; // see R10 see R12
    assign atHalf = engTick && (cnt_reg == halfLen - 13'h0001);
    // A period shortened at runtime ends on the next tick rather than wrapping the counter
    assign atEnd = engTick && (cnt_reg >= fullLen - 13'h0001); // see R4

    // Next count and event pulses
    always_comb begin
        cnt_next = cnt_reg;
        if (restart) begin
            cnt_next = 13'h0000;
        end else if (atEnd) begin
            cnt_next = 13'h0000;
        end else if (engTick) begin
            cnt_next = cnt_reg + 13'h0001;
        end
        midTick_next = atHalf && !restart;
        endTick_next = atEnd && !restart;
    end

    // Counter and registered pulses
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_reg <= 13'h0000;
            midTick <= 1'b0;
            endTick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            midTick <= midTick_next;
            endTick <= endTick_next;
        end
    end

endmodule : uart_bit_timer
